// ### bench/dual_timer_mode_select_assertions.sv
// checker for the dual timer mode select block
// one clock, async high reset; mode register mirrored from writes
`timescale 1ns/1ps
module dual_timer_mode_select_assertions import dual_timer_pkg::*; (
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire sfr_wr_t sfrWr, // writes
  input wire logic prescaleTick, // tick
  input wire logic tmrARun, // run a
  input wire logic [7:0] sfrRdAddr, // read address
  input wire logic [7:0] sfrRdData, // read data
  input wire logic [15:0] tmrACount, // count a
  input wire logic [15:0] tmrBCount, // count b
  input wire logic tmrAOverflow, // wrap a
  input wire logic tmrBOverflow); // wrap b
  // ====================
  // mirror of the mode register
  logic [7:0] mode_r;
  wire noWr = !sfrWr.wrEn;
  wire [1:0] modeA = mode_r[1:0];
  wire stepA = mode_r[3:0] == 4'h1 && tmrARun && prescaleTick && noWr;
  always_ff @(posedge core_clk or posedge rst)
    if (rst) mode_r <= MODE_SEL_RESET;
    else if (sfrWr.wrEn && sfrWr.addr == MODE_SEL_ADDR) mode_r <= sfrWr.wrData;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  stop_low_a: assert property (!tmrARun && noWr |=> $stable(tmrACount[7:0]))
    else $error("count a moved while stopped");
  b_inactive_a: assert property (mode_r[5:4] == 2'h3 && noWr |=> $stable(tmrBCount))
    else $error("count b moved in mode 3");
  step_one_a: assert property (stepA |=> tmrACount == $past(tmrACount) + 16'h1)
    else $error("count a missed a step");
  wrap_full_a: assert property (modeA == 2'h1 && tmrAOverflow |-> tmrACount == 16'h0)
    else $error("mode 1 wrap wrong");
  reload_lo_a: assert property (modeA == 2'h2 && tmrAOverflow |->
    tmrACount[7:0] == tmrACount[15:8]) else $error("mode 2 reload wrong");
  wrap_short_a: assert property (modeA == 2'h0 && tmrAOverflow |->
    tmrACount[15:8] == 8'h0 && tmrACount[4:0] == 5'h0) else $error("mode 0 wrap wrong");
  split_flag_a: assert property (modeA == 2'h3 && tmrBOverflow |->
    tmrACount[15:8] == 8'h0) else $error("split flag wrong");
  read_back_a: assert property (sfrRdAddr == MODE_SEL_ADDR && noWr |=> sfrRdData == mode_r)
    else $error("mode read back wrong");
endmodule : dual_timer_mode_select_assertions
bind dual_timer_mode_select dual_timer_mode_select_assertions chk (.core_clk, .rst, .sfrWr,
  .prescaleTick, .tmrARun, .sfrRdAddr, .sfrRdData, .tmrACount, .tmrBCount, .tmrAOverflow,
  .tmrBOverflow);

// ### bench/testbench.sv
// bench for the dual timer mode select block: table rows, pins, reads, reset
// drives inputs on the falling edge; the checker is bound separately
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin error_cnt++; \
  $display("Error %s exp %h seen %h", n, e, s); end end
module testbench import dual_timer_pkg::*;;
  typedef struct {logic [7:0] m, lo, hi; logic irq; int n; logic [15:0] a, b;} row_t;
  logic core_clk = 1'h0, rst, prescaleTick = 1'h0, tmrARun = 1'h0, tmrBRun = 1'h0;
  logic irq = 1'h1, pinA = 1'h1, tmrAOverflow, tmrBOverflow, baudTick;
  int flagACnt = 0, flagBCnt = 0, baudCnt = 0;
  logic [7:0] sfrRdAddr = MODE_SEL_ADDR, sfrRdData;
  logic [15:0] tmrACount, tmrBCount;
  sfr_wr_t sfrWr = '0;
  int error_cnt = 0, n_compared = 0;
  logic [7:0] adr [5] = '{MODE_SEL_ADDR, A_LOW_ADDR, A_HIGH_ADDR, B_LOW_ADDR, B_HIGH_ADDR};
  // ====================
  // mode, low, high, irq level, ticks, expected a and b
  row_t rows [7] = '{'{8'h11, 8'hff, 8'h00, 1'h1, 1, 16'h0100, 16'h0100},
    '{8'h00, 8'h1f, 8'hff, 1'h1, 1, 16'h0000, 16'h0000},
    '{8'h22, 8'hfe, 8'h80, 1'h1, 3, 16'h8081, 16'h8081},
    '{8'h31, 8'h10, 8'h00, 1'h1, 2, 16'h0012, 16'h0010},
    '{8'h99, 8'h10, 8'h00, 1'h0, 2, 16'h0010, 16'h0010},
    '{8'h99, 8'hff, 8'hff, 1'h1, 2, 16'h0001, 16'h0001},
    '{8'h13, 8'h10, 8'hff, 1'h1, 2, 16'h0112, 16'hff12}};
  dual_timer_mode_select dual_timer_mode_select_inst (.core_clk, .rst, .sfrWr, .sfrRdAddr,
    .prescaleTick, .tmrARun, .tmrBRun, .tmrACountPin(pinA), .tmrBCountPin(1'h1),
    .extIrqA_n(irq), .extIrqB_n(irq), .sfrRdData, .tmrACount, .tmrBCount, .tmrAOverflow,
    .tmrBOverflow, .baudTick);
  initial forever #50 core_clk = ~core_clk;
  // pulses counted away from the edge that launches them
  always @(negedge core_clk) begin
    if (tmrAOverflow === 1'h1) flagACnt++;
    if (tmrBOverflow === 1'h1) flagBCnt++;
    if (baudTick === 1'h1) baudCnt++;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk) sfrWr = '{a, d, 1'h1};
  endtask : wr
  // strobe stays up across the five writes, dropped once at the end
  task automatic load(input row_t r);
    for (int k = 0; k < 5; k++) wr(adr[k], k == 0 ? r.m : (k % 2 ? r.lo : r.hi));
    @(negedge core_clk) sfrWr.wrEn = 1'h0;
    `CHK("mode readback", r.m, sfrRdData)
  endtask : load
  task automatic do_reset;
    rst = 1'h1;
    repeat (5) @(negedge core_clk);
    `CHK("reset count a", 16'h0000, tmrACount)
    `CHK("reset count b", 16'h0000, tmrBCount)
    `CHK("reset mode", MODE_SEL_RESET, sfrRdData)
    rst = 1'h0;
    $display("reset test done");
  endtask : do_reset
  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // watchdog: some ten times the expected run
  initial begin
    #100us;
    error_cnt++;
    finish_test();
  end
  initial begin
    do_reset();
    @(negedge core_clk);
    tmrARun = 1'h1;
    tmrBRun = 1'h1;
    foreach (rows[i]) begin
      irq = rows[i].irq;
      load(rows[i]);
      repeat (rows[i].n) @(negedge core_clk) prescaleTick = 1'h1;
      @(negedge core_clk) prescaleTick = 1'h0;
      `CHK("count a", rows[i].a, tmrACount)
      `CHK("count b", rows[i].b, tmrBCount)
      $display("row %0d done", i);
    end
    // held tick must be ignored when counting pin edges
    load('{8'h05, 8'h00, 8'h00, 1'h1, 0, 16'h0003, 16'h0000});
    prescaleTick = 1'h1;
    repeat (6) begin
      repeat (3) @(negedge core_clk);
      pinA = ~pinA;
    end
    prescaleTick = 1'h0;
    repeat (4) @(negedge core_clk);
    `CHK("pin count", 16'h0003, tmrACount)
    `CHK("first flag pulses", 3, flagACnt)
    `CHK("second flag pulses", 4, flagBCnt)
    `CHK("baud pulses", 3, baudCnt)
    sfrRdAddr = 8'h90;
    @(negedge core_clk);
    `CHK("unmapped read", 8'h00, sfrRdData)
    sfrRdAddr = MODE_SEL_ADDR;
    $display("pin and read tests done");
    do_reset();
    finish_test();
  end
endmodule : testbench

// ### design/dual_timer_mode_select.sv
// two basic 16-bit counter/timers with their mode select register
// assumes an sfr write strobe and a prescaled clock tick from the core, both on core_clk;
// count pins and interrupt pins are asynchronous and synchronised here
//
// Operation
// - gate 0 counts on run alone; gate 1 also needs interrupt input high.
// - mode field 00 makes a 13-bit counter/timer.
// - mode field 01 makes a full 16-bit counter/timer.
// - mode field 10 makes an 8-bit counter reloading on overflow.
// - second timer in mode 11 is inactive and stops counting.
// - first timer mode 3 low byte is 8-bit using its own controls.
// - split high byte counts clock, runs on second run bit, sets second flag.
// - while split, second timer gets no pin edges, no flag, still baud tick.
`timescale 1ns/1ps
module dual_timer_mode_select
  import dual_timer_pkg::*;
(
  input wire logic core_clk, // system clock, 10 MHz
  input wire logic rst, // async reset, active high
  input wire sfr_wr_t sfrWr, // sfr write address, data and strobe
  input wire logic [7:0] sfrRdAddr, // sfr read address
  input wire logic prescaleTick, // one-cycle prescaled clock enable
  input wire logic tmrARun, // first timer run bit
  input wire logic tmrBRun, // second timer run bit
  input wire logic tmrACountPin, // first timer external count pin, async
  input wire logic tmrBCountPin, // second timer external count pin, async
  input wire logic extIrqA_n, // first external interrupt input, async
  input wire logic extIrqB_n, // second external interrupt input, async
  output logic [7:0] sfrRdData, // read data for sfrRdAddr, registered
  output logic [15:0] tmrACount, // first timer high and low byte
  output logic [15:0] tmrBCount, // second timer high and low byte
  output logic tmrAOverflow, // pulse: sets first overflow flag
  output logic tmrBOverflow, // pulse: sets second overflow flag
  output logic baudTick // pulse: second timer overflow for serial baud
);

  // ==========================================================
  // synchronisers and edge detection
  logic [3:0] pinMeta_r;
  logic [3:0] pinSync_r;
  logic [1:0] pinLast_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pinMeta_r <= 4'h0;
      pinSync_r <= 4'h0;
      pinLast_r <= 2'h0;
    end else begin
      pinMeta_r <= {extIrqB_n, extIrqA_n, tmrBCountPin, tmrACountPin};
      pinSync_r <= pinMeta_r;
      pinLast_r <= pinSync_r[1:0];
    end
  end

  wire pinFallA = pinLast_r[0] & ~pinSync_r[0];
  wire pinFallB = pinLast_r[1] & ~pinSync_r[1];
  wire irqLevelA = pinSync_r[2];
  wire irqLevelB = pinSync_r[3];

  // ==========================================================
  // mode select register
  logic [7:0] modeSel_r;
  logic [7:0] modeSel_nxt;
  wire modeSelWr = sfrWr.wrEn && (sfrWr.addr == MODE_SEL_ADDR);

  assign modeSel_nxt = modeSelWr ? sfrWr.wrData : modeSel_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      modeSel_r <= MODE_SEL_RESET;
    end else begin
      modeSel_r <= modeSel_nxt;
    end
  end

  tmr_cfg_t cfgA;
  tmr_cfg_t cfgB;
  assign cfgA.gate = modeSel_r[A_GATE_BIT];
  assign cfgA.source = modeSel_r[A_SOURCE_BIT];
  assign cfgA.mode = tmr_mode_t'({modeSel_r[A_MODE_HI_BIT], modeSel_r[A_MODE_LO_BIT]});
  assign cfgB.gate = modeSel_r[B_GATE_BIT];
  assign cfgB.source = modeSel_r[B_SOURCE_BIT];
  assign cfgB.mode = tmr_mode_t'({modeSel_r[B_MODE_HI_BIT], modeSel_r[B_MODE_LO_BIT]});

  wire splitA = (cfgA.mode == MODE_SPLIT);

  // ==========================================================
  // address match shared by the counter write strobes and the read mux
  function automatic logic hitAddr(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction : hitAddr

  // ==========================================================
  // one increment of a timer in the given mode: {overflow, high, low}
  function automatic logic [16:0] stepCount(input tmr_mode_t mode, input logic [7:0] lo,
                                            input logic [7:0] hi);
    logic [16:0] res;
    res = {1'b0, hi, lo};
    case (mode)
      MODE_13BIT: begin
        // low five bits prescale the high byte; upper low bits hold
        if (lo[4:0] == PRESCALER13_MAX) begin
          res = {(hi == BYTE_MAX), hi + 8'h01, lo[7:5], 5'h00};
        end else begin
          res = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
        end
      end
      MODE_16BIT: begin
        res = {1'b0, hi, lo} + 17'h00001;
      end
      MODE_8BIT_RELOAD: begin
        if (lo == BYTE_MAX) begin
          res = {1'b1, hi, hi};
        end else begin
          res = {1'b0, hi, lo + 8'h01};
        end
      end
      default: begin
        // low byte alone, eight bits wide
        res = {(lo == BYTE_MAX), hi, lo + 8'h01};
      end
    endcase
    return res;
  endfunction : stepCount

  // ==========================================================
  // count enables
  wire gateOkA = ~cfgA.gate | irqLevelA;
  wire gateOkB = ~cfgB.gate | irqLevelB;
  wire tickA = cfgA.source ? pinFallA : prescaleTick;
  // while split the second timer loses its pin and its run bit
  wire tickB = (cfgB.source && !splitA) ? pinFallB : prescaleTick;
  wire runB = splitA ? 1'b1 : (tmrBRun & gateOkB);
  wire incA = tmrARun & gateOkA & tickA;
  wire incB = runB & tickB & (cfgB.mode != MODE_SPLIT);
  wire incAHigh = splitA & tmrBRun & prescaleTick;

  // ==========================================================
  // counters
  logic [7:0] aLow_r;
  logic [7:0] aHigh_r;
  logic [7:0] bLow_r;
  logic [7:0] bHigh_r;
  logic [16:0] stepA;
  logic [16:0] stepB;
  logic [7:0] aLow_nxt;
  logic [7:0] aHigh_nxt;
  logic [7:0] bLow_nxt;
  logic [7:0] bHigh_nxt;

  assign stepA = stepCount(cfgA.mode, aLow_r, aHigh_r);
  assign stepB = stepCount(cfgB.mode, bLow_r, bHigh_r);

  wire wrALow = sfrWr.wrEn && hitAddr(sfrWr.addr, A_LOW_ADDR);
  wire wrAHigh = sfrWr.wrEn && hitAddr(sfrWr.addr, A_HIGH_ADDR);
  wire wrBLow = sfrWr.wrEn && hitAddr(sfrWr.addr, B_LOW_ADDR);
  wire wrBHigh = sfrWr.wrEn && hitAddr(sfrWr.addr, B_HIGH_ADDR);

  wire ovfA = incA & stepA[16];
  wire ovfAHigh = incAHigh & (aHigh_r == BYTE_MAX);
  wire ovfB = incB & stepB[16];

  // software write wins over a count in the same cycle
  assign aLow_nxt = wrALow ? sfrWr.wrData : (incA ? stepA[7:0] : aLow_r);
  assign bLow_nxt = wrBLow ? sfrWr.wrData : (incB ? stepB[7:0] : bLow_r);
  assign bHigh_nxt = wrBHigh ? sfrWr.wrData : (incB ? stepB[15:8] : bHigh_r);
  assign aHigh_nxt = wrAHigh ? sfrWr.wrData :
                     splitA ? (incAHigh ? aHigh_r + 8'h01 : aHigh_r) :
                     (incA ? stepA[15:8] : aHigh_r);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aLow_r <= COUNT_RESET;
      aHigh_r <= COUNT_RESET;
      bLow_r <= COUNT_RESET;
      bHigh_r <= COUNT_RESET;
    end else begin
      aLow_r <= aLow_nxt;
      aHigh_r <= aHigh_nxt;
      bLow_r <= bLow_nxt;
      bHigh_r <= bHigh_nxt;
    end
  end

  // ==========================================================
  // outputs
  // unmapped addresses read as zero
  logic [7:0] rdMux;

  always_comb begin
    if (hitAddr(sfrRdAddr, MODE_SEL_ADDR)) begin
      rdMux = modeSel_r;
    end else if (hitAddr(sfrRdAddr, A_LOW_ADDR)) begin
      rdMux = aLow_r;
    end else if (hitAddr(sfrRdAddr, B_LOW_ADDR)) begin
      rdMux = bLow_r;
    end else if (hitAddr(sfrRdAddr, A_HIGH_ADDR)) begin
      rdMux = aHigh_r;
    end else if (hitAddr(sfrRdAddr, B_HIGH_ADDR)) begin
      rdMux = bHigh_r;
    end else begin
      rdMux = 8'h00;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sfrRdData <= 8'h00;
      tmrACount <= 16'h0000;
      tmrBCount <= 16'h0000;
      tmrAOverflow <= 1'b0;
      tmrBOverflow <= 1'b0;
      baudTick <= 1'b0;
    end else begin
      sfrRdData <= rdMux;
      tmrACount <= {aHigh_nxt, aLow_nxt};
      tmrBCount <= {bHigh_nxt, bLow_nxt};
      tmrAOverflow <= ovfA;
      // split high byte takes over the second flag
      tmrBOverflow <= splitA ? ovfAHigh : ovfB;
      baudTick <= ovfB;
    end
  end

endmodule : dual_timer_mode_select

// ### design/dual_timer_pkg.sv
// package for the dual timer mode-select block
// shared offsets, field positions, reset values, mode codes and carriers
package dual_timer_pkg;

  // ==========================================================
  // special function register offsets
  localparam logic [7:0] MODE_SEL_ADDR = 8'h89;
  localparam logic [7:0] A_LOW_ADDR = 8'h8a;
  localparam logic [7:0] B_LOW_ADDR = 8'h8b;
  localparam logic [7:0] A_HIGH_ADDR = 8'h8c;
  localparam logic [7:0] B_HIGH_ADDR = 8'h8d;

  // ==========================================================
  // reset values
  localparam logic [7:0] MODE_SEL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  // ==========================================================
  // field positions inside the mode select register
  localparam int B_GATE_BIT = 7;
  localparam int B_SOURCE_BIT = 6;
  localparam int B_MODE_HI_BIT = 5;
  localparam int B_MODE_LO_BIT = 4;
  localparam int A_GATE_BIT = 3;
  localparam int A_SOURCE_BIT = 2;
  localparam int A_MODE_HI_BIT = 1;
  localparam int A_MODE_LO_BIT = 0;

  // ==========================================================
  // counter limits
  localparam logic [4:0] PRESCALER13_MAX = 5'h1f;
  localparam logic [7:0] BYTE_MAX = 8'hff;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_8BIT_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } tmr_mode_t;

  typedef struct packed {
    logic gate;
    logic source;
    tmr_mode_t mode;
  } tmr_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wrEn;
  } sfr_wr_t;

endpackage : dual_timer_pkg
